// [rtl/flash_status_regs.sv]
// Status and protection registers of a serial NOR flash with a serial status readout.
// How it works
// - Write enable command sets the latch.
// - Reset, disable, completed writes clear the latch.
// - Four protect level bits, writable, reset zero.
// - Bottom bit picks array end, writes gated.
// - Lock mode 00: writes need only latch.
// - Lock mode 01: write-protect pin low blocks.
// - Lock mode 10: writes blocked until next reset.
// - Mode 10 returns to 00 on reset.
// - Lock mode 11 blocks status writes until power cycle.
// - Quad enable turns pin functions into data.
// - Suspend sets erase or program suspend flag.
// - Resume, software reset, power cycle clear flags.
// - Role select picks pause or reset pin.
// - Security lock bits set once, cleared only by power-up.
// - Invert bit complements the protection map.
// - Drive code maps to 50/25/75/100 percent.
// - Scheme select picks map or lock bits.
// - All lock bits set after any reset.
// - Program fault on failure or protected target.
// - Erase fault on failure or protected target.
// - Address width flag shows three/four bytes.
// - While busy only status reads and suspend are served.
`timescale 1ns/10ps
`include "flash_status_params.svh"

module flash_status_regs
    import flash_status_pkg::*;
#(
    parameter int LOCK_DEPTH = `LOCK_DEPTH,
    parameter int AW = `LOCK_AW
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CMD_STB_I,
    input wire logic [7:0] CMD_OP_I,
    input wire logic [7:0] CMD_DATA_I,
    input wire logic CMD_ARRAY_PROT_I,
    input wire logic [1:0] CMD_OTP_AREA_I,
    input wire logic [AW-1:0] CMD_LOCK_IDX_I,
    input wire logic OP_DONE_I,
    input wire logic OP_FAIL_I,
    input wire logic WP_N_I,
    input wire logic HOLD_RST_N_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    output logic SO_O,
    output logic BUSY_O,
    output logic START_PROG_O,
    output logic START_ERASE_O,
    output logic START_WRSR_O,
    output logic SUSPEND_O,
    output logic RESUME_O,
    output logic ENGINE_RESET_O,
    output logic PAUSE_O,
    output logic DATA_LINES_O,
    output logic [3:0] PROT_LEVEL_O,
    output logic PROT_BOTTOM_O,
    output logic PROT_INVERT_O,
    output logic PROT_SCHEME_O,
    output logic [2:0] SECURE_LOCK_O,
    output logic [6:0] DRIVE_PCT_O,
    output logic ADDR_4B_O
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Bit order: 3 write protect, 2 pause/reset, 1 serial clock (resets to its idle low level), 0 select.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic sck_d_r;

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pin_s1_r <= 4'hD;
            pin_s2_r <= 4'hD;
            sck_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {WP_N_I, HOLD_RST_N_I, SCK_I, CS_N_I};
            pin_s2_r <= pin_s1_r;
            sck_d_r <= pin_s2_r[1];
        end
    end

    // ------------------------------------------------------------
    // Register state and decoded fields
    // ------------------------------------------------------------
    logic [7:0] sr1_r, sr1_nxt;
    logic [7:0] sr2_r, sr2_nxt;
    logic [7:0] sr3_r, sr3_nxt;
    logic wel_r, wel_nxt;
    logic sus_e_r, sus_e_nxt;
    logic sus_p_r, sus_p_nxt;
    logic pe_r, pe_nxt;
    logic ee_r, ee_nxt;
    logic ads_r, ads_nxt;
    logic arm_r, arm_nxt;
    run_state_t state_r, state_nxt;
    logic start_prog_nxt, start_erase_nxt, start_wrsr_nxt;
    logic suspend_nxt, resume_nxt;
    logic pause_nxt;
    logic [6:0] drive_nxt;
    logic soft_rst;
    logic lock_wr;
    logic lock_val;
    logic lock_bit;
    logic busy;
    logic quad;
    logic wp_eff;
    logic hw_rst;
    logic sr_unlocked;
    logic tgt_prot;
    logic [2:0] lb;
    logic [7:0] sr1_rd, sr2_rd, sr3_rd;

    assign busy = (state_r != ST_IDLE);
    assign quad = sr2_r[`SR2_QE];
    assign lb = sr2_r[`SR2_LB_LO +: 3];
    // With quad mode on the pin is a data line, so it no longer protects.
    assign wp_eff = quad | pin_s2_r[3];
    assign hw_rst = !quad && sr3_r[`SR3_PIN3_ROLE_SELECT] && !pin_s2_r[2];

    always_comb begin
        case ({sr2_r[`SR2_STATUS_LOCK_MODE_HI], sr1_r[`SR1_STATUS_LOCK_MODE_LO]})
            2'b00: sr_unlocked = 1'b1;
            2'b01: sr_unlocked = wp_eff;
            2'b10: sr_unlocked = 1'b0;
            default: sr_unlocked = 1'b0;
        endcase
    end

    // Scheme select chooses between the map input and the individual lock bit.
    always_comb begin
        tgt_prot = sr3_r[`SR3_WPS] ? lock_bit : CMD_ARRAY_PROT_I;
        if (CMD_OTP_AREA_I != 2'h0) begin
            tgt_prot = lb[CMD_OTP_AREA_I - 2'h1];
        end
    end

    assign sr1_rd = (sr1_r & `SR1_WMASK) | ({7'h00, wel_r} << `SR1_WEL) | {7'h00, busy};
    assign sr2_rd = (sr2_r & (`SR2_WMASK | `SR2_OTP_MASK)) | ({7'h00, sus_e_r} << `SR2_ERASE_SUSPENDED)
                  | ({7'h00, sus_p_r} << `SR2_PROGRAM_SUSPENDED);
    assign sr3_rd = (sr3_r & `SR3_WMASK) | ({7'h00, ee_r} << `SR3_EE) | ({7'h00, pe_r} << `SR3_PE)
                  | {7'h00, ads_r};

    // ------------------------------------------------------------
    // Command handling
    // ------------------------------------------------------------
    always_comb begin
        sr1_nxt = sr1_r;
        sr2_nxt = sr2_r;
        sr3_nxt = sr3_r;
        wel_nxt = wel_r;
        sus_e_nxt = sus_e_r;
        sus_p_nxt = sus_p_r;
        pe_nxt = pe_r;
        ee_nxt = ee_r;
        ads_nxt = ads_r;
        arm_nxt = arm_r;
        state_nxt = state_r;
        start_prog_nxt = 1'b0;
        start_erase_nxt = 1'b0;
        start_wrsr_nxt = 1'b0;
        suspend_nxt = 1'b0;
        resume_nxt = 1'b0;
        lock_wr = 1'b0;
        lock_val = 1'b0;
        soft_rst = hw_rst;
        if (busy && OP_DONE_I) begin
            if (state_r == ST_PROG && OP_FAIL_I) begin
                pe_nxt = 1'b1;
            end
            if (state_r == ST_ERASE && OP_FAIL_I) begin
                ee_nxt = 1'b1;
            end
            wel_nxt = 1'b0;
            state_nxt = ST_IDLE;
        end
        if (CMD_STB_I && !hw_rst) begin
            arm_nxt = (CMD_OP_I == `OP_RSTEN) && !busy;
            if (busy) begin
                // Only a suspend may cut into a running program or erase.
                if (CMD_OP_I == `OP_SUSPEND && state_r != ST_WRSR && !OP_DONE_I) begin
                    sus_e_nxt = sus_e_r | (state_r == ST_ERASE);
                    sus_p_nxt = sus_p_r | (state_r == ST_PROG);
                    state_nxt = ST_IDLE;
                    suspend_nxt = 1'b1;
                end
            end else begin
                case (CMD_OP_I)
                    `OP_WREN: begin
                        wel_nxt = 1'b1;
                    end
                    `OP_WRDI: begin
                        wel_nxt = 1'b0;
                    end
                    `OP_PP: begin
                        if (wel_r && tgt_prot) begin
                            pe_nxt = 1'b1;
                            wel_nxt = 1'b0;
                        end else if (wel_r) begin
                            pe_nxt = 1'b0;
                            state_nxt = ST_PROG;
                            start_prog_nxt = 1'b1;
                        end
                    end
                    `OP_SE, `OP_BE, `OP_CE: begin
                        if (wel_r && tgt_prot) begin
                            ee_nxt = 1'b1;
                            wel_nxt = 1'b0;
                        end else if (wel_r) begin
                            ee_nxt = 1'b0;
                            state_nxt = ST_ERASE;
                            start_erase_nxt = 1'b1;
                        end
                    end
                    `OP_WRSR1: begin
                        if (wel_r && sr_unlocked) begin
                            sr1_nxt = (sr1_r & ~`SR1_WMASK) | (CMD_DATA_I & `SR1_WMASK);
                            state_nxt = ST_WRSR;
                            start_wrsr_nxt = 1'b1;
                        end
                    end
                    `OP_WRSR2: begin
                        if (wel_r && sr_unlocked) begin
                            sr2_nxt = (sr2_r & ~`SR2_WMASK) | (CMD_DATA_I & `SR2_WMASK)
                                    | (CMD_DATA_I & `SR2_OTP_MASK);
                            state_nxt = ST_WRSR;
                            start_wrsr_nxt = 1'b1;
                        end
                    end
                    `OP_WRSR3: begin
                        if (wel_r && sr_unlocked) begin
                            sr3_nxt = (sr3_r & ~`SR3_WMASK) | (CMD_DATA_I & `SR3_WMASK);
                            state_nxt = ST_WRSR;
                            start_wrsr_nxt = 1'b1;
                        end
                    end
                    `OP_RESUME: begin
                        // A program suspended inside an erase suspend resumes first.
                        if (sus_p_r) begin
                            sus_p_nxt = 1'b0;
                            pe_nxt = 1'b0;
                            state_nxt = ST_PROG;
                            resume_nxt = 1'b1;
                        end else if (sus_e_r) begin
                            sus_e_nxt = 1'b0;
                            ee_nxt = 1'b0;
                            state_nxt = ST_ERASE;
                            resume_nxt = 1'b1;
                        end
                    end
                    `OP_RST: begin
                        soft_rst = arm_r;
                    end
                    `OP_EN4B: begin
                        ads_nxt = 1'b1;
                    end
                    `OP_EX4B: begin
                        ads_nxt = 1'b0;
                    end
                    `OP_BLK_LOCK, `OP_BLK_UNLOCK: begin
                        lock_wr = 1'b1;
                        lock_val = (CMD_OP_I == `OP_BLK_LOCK);
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (soft_rst) begin
            wel_nxt = 1'b0;
            sus_e_nxt = 1'b0;
            sus_p_nxt = 1'b0;
            arm_nxt = 1'b0;
            ads_nxt = sr3_r[`SR3_ADP];
            state_nxt = ST_IDLE;
            if ({sr2_r[`SR2_STATUS_LOCK_MODE_HI], sr1_r[`SR1_STATUS_LOCK_MODE_LO]} == 2'b10) begin
                sr1_nxt[`SR1_STATUS_LOCK_MODE_LO] = 1'b0;
                sr2_nxt[`SR2_STATUS_LOCK_MODE_HI] = 1'b0;
            end
        end
        pause_nxt = !quad && !sr3_r[`SR3_PIN3_ROLE_SELECT] && !pin_s2_r[2];
        case (sr3_r[`SR3_DRV_LO +: 2])
            2'b00: drive_nxt = `DRV_PCT_00;
            2'b01: drive_nxt = `DRV_PCT_01;
            2'b10: drive_nxt = `DRV_PCT_10;
            default: drive_nxt = `DRV_PCT_11;
        endcase
    end

    // Power-up stands in for a power cycle: all factory values return here.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sr1_r <= `SR_RESET;
            sr2_r <= `SR_RESET;
            sr3_r <= `SR_RESET;
            wel_r <= 1'b0;
            sus_e_r <= 1'b0;
            sus_p_r <= 1'b0;
            pe_r <= 1'b0;
            ee_r <= 1'b0;
            ads_r <= 1'b0;
            arm_r <= 1'b0;
            state_r <= ST_IDLE;
            START_PROG_O <= 1'b0;
            START_ERASE_O <= 1'b0;
            START_WRSR_O <= 1'b0;
            SUSPEND_O <= 1'b0;
            RESUME_O <= 1'b0;
            ENGINE_RESET_O <= 1'b0;
            PAUSE_O <= 1'b0;
            DRIVE_PCT_O <= `DRV_PCT_00;
        end else begin
            sr1_r <= sr1_nxt;
            sr2_r <= sr2_nxt;
            sr3_r <= sr3_nxt;
            wel_r <= wel_nxt;
            sus_e_r <= sus_e_nxt;
            sus_p_r <= sus_p_nxt;
            pe_r <= pe_nxt;
            ee_r <= ee_nxt;
            ads_r <= ads_nxt;
            arm_r <= arm_nxt;
            state_r <= state_nxt;
            START_PROG_O <= start_prog_nxt;
            START_ERASE_O <= start_erase_nxt;
            START_WRSR_O <= start_wrsr_nxt;
            SUSPEND_O <= suspend_nxt;
            RESUME_O <= resume_nxt;
            ENGINE_RESET_O <= hw_rst;
            PAUSE_O <= pause_nxt;
            DRIVE_PCT_O <= drive_nxt;
        end
    end

    flash_lock_mem #(
        .DEPTH(LOCK_DEPTH),
        .AW(AW)
    ) u_lock_mem (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .set_all_i(soft_rst),
        .wr_i(lock_wr),
        .wr_idx_i(CMD_LOCK_IDX_I),
        .wr_val_i(lock_val),
        .rd_idx_i(CMD_LOCK_IDX_I),
        .rd_bit_o(lock_bit)
    );

    assign BUSY_O = busy;
    assign DATA_LINES_O = quad;
    assign PROT_LEVEL_O = sr1_r[`SR1_BP_LO +: 4];
    assign PROT_BOTTOM_O = sr1_r[`SR1_TB];
    assign PROT_INVERT_O = sr2_r[`SR2_CMP];
    assign PROT_SCHEME_O = sr3_r[`SR3_WPS];
    assign SECURE_LOCK_O = lb;
    assign ADDR_4B_O = ads_r;

    // ------------------------------------------------------------
    // Serial status readout
    // ------------------------------------------------------------
    // The status byte is reloaded after every eighth bit, so polling sees busy fall live.
    logic [7:0] sh_r, sh_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic act_r, act_nxt;
    logic sck_fall;
    logic [7:0] live;

    assign sck_fall = sck_d_r && !pin_s2_r[1];

    always_comb begin
        case (sel_r)
            2'h1: live = sr2_rd;
            2'h2: live = sr3_rd;
            default: live = sr1_rd;
        endcase
    end

    always_comb begin
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        sel_nxt = sel_r;
        act_nxt = act_r && !pin_s2_r[0];
        if (CMD_STB_I && (CMD_OP_I == `OP_RDSR1 || CMD_OP_I == `OP_RDSR2 || CMD_OP_I == `OP_RDSR3)) begin
            sel_nxt = (CMD_OP_I == `OP_RDSR2) ? 2'h1 : ((CMD_OP_I == `OP_RDSR3) ? 2'h2 : 2'h0);
            sh_nxt = (CMD_OP_I == `OP_RDSR2) ? sr2_rd : ((CMD_OP_I == `OP_RDSR3) ? sr3_rd : sr1_rd);
            cnt_nxt = 3'h0;
            act_nxt = 1'b1;
        end else if (act_r && sck_fall) begin
            sh_nxt = (cnt_r == 3'h7) ? live : {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 3'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            sh_r <= 8'h00;
            cnt_r <= 3'h0;
            sel_r <= 2'h0;
            act_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            sel_r <= sel_nxt;
            act_r <= act_nxt;
        end
    end

    assign SO_O = sh_r[7];
endmodule

// [rtl/flash_status_params.svh]
// Constants for the flash status and protection register block.
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH

// Serial command opcodes seen by this block.
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PP 8'h02
`define OP_SE 8'h20
`define OP_BE 8'hD8
`define OP_CE 8'hC7
`define OP_WRSR1 8'h01
`define OP_WRSR2 8'h31
`define OP_WRSR3 8'h11
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define OP_RDSR3 8'h15
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_RSTEN 8'h66
`define OP_RST 8'h99
`define OP_EN4B 8'hB7
`define OP_EX4B 8'hE9
`define OP_BLK_LOCK 8'h36
`define OP_BLK_UNLOCK 8'h39

// Field positions.
`define SR1_BUSY 0
`define SR1_WEL 1
`define SR1_BP_LO 2
`define SR1_TB 6
`define SR1_STATUS_LOCK_MODE_LO 7
`define SR2_STATUS_LOCK_MODE_HI 0
`define SR2_QE 1
`define SR2_PROGRAM_SUSPENDED 2
`define SR2_LB_LO 3
`define SR2_CMP 6
`define SR2_ERASE_SUSPENDED 7
`define SR3_ADS 0
`define SR3_ADP 1
`define SR3_WPS 2
`define SR3_PE 3
`define SR3_EE 4
`define SR3_DRV_LO 5
`define SR3_PIN3_ROLE_SELECT 7

// Writable and one-time-settable bits of each status register.
`define SR1_WMASK 8'hFC
`define SR2_WMASK 8'h43
`define SR2_OTP_MASK 8'h38
`define SR3_WMASK 8'hE6
`define SR_RESET 8'h00

// Drive strength percentages and the individual lock bit count.
`define DRV_PCT_00 7'h32
`define DRV_PCT_01 7'h19
`define DRV_PCT_10 7'h4B
`define DRV_PCT_11 7'h64
`define LOCK_DEPTH 'h21E
`define LOCK_AW 'hA

`endif

// [rtl/flash_status_pkg.sv]
// Types shared by the flash status and protection register block.
package flash_status_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PROG = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_WRSR = 4'b1000
    } run_state_t;
endpackage

// [rtl/flash_lock_mem.sv]
// Individual sector/block lock bit store with a registered read port.
`timescale 1ns/10ps
`include "flash_status_params.svh"

module flash_lock_mem #(
    parameter int DEPTH = `LOCK_DEPTH,
    parameter int AW = `LOCK_AW
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic set_all_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] wr_idx_i,
    input wire logic wr_val_i,
    input wire logic [AW-1:0] rd_idx_i,
    output logic rd_bit_o
);
    logic [DEPTH-1:0] bits_r;
    logic [DEPTH-1:0] bits_nxt;
    logic rd_bit_nxt;

    // Indices past the end read as locked, so a stray index never opens the array.
    always_comb begin
        bits_nxt = bits_r;
        if (set_all_i) begin
            bits_nxt = '1;
        end else if (wr_i && (int'(wr_idx_i) < DEPTH)) begin
            bits_nxt[wr_idx_i] = wr_val_i;
        end
        rd_bit_nxt = (int'(rd_idx_i) < DEPTH) ? bits_r[rd_idx_i] : 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bits_r <= '1;
            rd_bit_o <= 1'b1;
        end else begin
            bits_r <= bits_nxt;
            rd_bit_o <= rd_bit_nxt;
        end
    end
endmodule

// [dv/flash_status_props.sv]
// Assertion checker for the flash status and protection register block.
`timescale 1ns/10ps
`include "flash_status_params.svh"
module flash_status_props (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CMD_STB_I,
    input wire logic [7:0] CMD_OP_I,
    input wire logic OP_DONE_I,
    input wire logic BUSY_O,
    input wire logic START_PROG_O,
    input wire logic START_ERASE_O,
    input wire logic START_WRSR_O,
    input wire logic SUSPEND_O,
    input wire logic RESUME_O,
    input wire logic ENGINE_RESET_O,
    input wire logic PAUSE_O,
    input wire logic DATA_LINES_O,
    input wire logic [3:0] PROT_LEVEL_O,
    input wire logic PROT_BOTTOM_O,
    input wire logic PROT_INVERT_O,
    input wire logic PROT_SCHEME_O,
    input wire logic [2:0] SECURE_LOCK_O,
    input wire logic [6:0] DRIVE_PCT_O
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_start;
        START_PROG_O || START_ERASE_O || START_WRSR_O;
    endsequence
    sequence s_done;
        BUSY_O && OP_DONE_I;
    endsequence
    sequence s_cfg_moved;
        $changed({PROT_LEVEL_O, PROT_BOTTOM_O, PROT_INVERT_O, PROT_SCHEME_O, SECURE_LOCK_O, DATA_LINES_O});
    endsequence
    AST_CFG_ONLY_BY_WRITE: assert property (s_cfg_moved |-> START_WRSR_O)
        else $error("config bits moved without an accepted status write");
    AST_START_FROM_IDLE: assert property (s_start |-> BUSY_O && !$past(BUSY_O))
        else $error("operation started while busy or without busy");
    AST_DONE_IDLE: assert property (s_done |=> !BUSY_O)
        else $error("busy kept after completion");
    AST_DRIVE_CODE: assert property (DRIVE_PCT_O inside {7'h32, 7'h19, 7'h4B, 7'h64})
        else $error("drive level outside the four codes");
    AST_DRIVE_RESET: assert property ($rose(RST_N_I) |-> DRIVE_PCT_O == 7'h32)
        else $error("drive level not fifty after reset");
    AST_SECURE_STICKY: assert property (($past(SECURE_LOCK_O) & ~SECURE_LOCK_O) == 3'b000)
        else $error("security lock bit cleared");
    AST_QUAD_PINS: assert property (DATA_LINES_O [*3] |-> !PAUSE_O && !ENGINE_RESET_O)
        else $error("pin function active with quad enabled");
    AST_SUSPEND_CAUSE: assert property (SUSPEND_O |-> $past(CMD_STB_I && BUSY_O && CMD_OP_I == `OP_SUSPEND))
        else $error("suspend without a suspend command while busy");
    AST_RESUME_CAUSE: assert property (RESUME_O |-> $past(CMD_STB_I && CMD_OP_I == `OP_RESUME))
        else $error("resume without a resume command");
endmodule
bind flash_status_regs flash_status_props u_props (.CLK_I, .RST_N_I, .CMD_STB_I, .CMD_OP_I, .OP_DONE_I,
    .BUSY_O, .START_PROG_O, .START_ERASE_O, .START_WRSR_O, .SUSPEND_O, .RESUME_O, .ENGINE_RESET_O,
    .PAUSE_O, .DATA_LINES_O, .PROT_LEVEL_O, .PROT_BOTTOM_O, .PROT_INVERT_O, .PROT_SCHEME_O,
    .SECURE_LOCK_O, .DRIVE_PCT_O);

// [dv/flash_host_model.sv]
// Host-side serial status reader that drives the link clock and chip select.
`timescale 1ns/10ps
module flash_host_model (
    output logic sck_o,
    output logic cs_n_o,
    input wire logic so_i
);
    // The link clock idles low and only runs inside a frame.
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // Select must already be low when the read command is taken, or the block drops the readout.
    task automatic frame(input logic on);
        cs_n_o = !on;
    endtask
    task automatic xfer(output logic [7:0] b);
        #37;
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b1;
            #400 b[i] = so_i;
            sck_o = 1'b0;
            #400;
        end
    endtask
endmodule

// [dv/test_flash_status_regs.sv]
// Self-checking bench for the flash status and protection register block.
`timescale 1ns/10ps
`include "flash_status_params.svh"
module test_flash_status_regs;
    logic clk, rst_n, stb, prot, done_p, fail, wp_n, hold_n;
    logic [7:0] op, dat, got;
    logic sck, cs_n, so, busy, sp, se, sw, sus, res, er, pause, dl, pb, pi, ps, a4;
    logic [3:0] lvl;
    logic [2:0] sl;
    logic [6:0] drv;
    logic [1:0] area;
    logic [4:0] pulses;
    logic [7:0] drv_tab [4] = '{8'h32, 8'h19, 8'h4B, 8'h64};
    int failures = 0;
    int cmp_count = 0;
    flash_status_regs u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_STB_I(stb), .CMD_OP_I(op), .CMD_DATA_I(dat),
        .CMD_ARRAY_PROT_I(prot), .CMD_OTP_AREA_I(area), .CMD_LOCK_IDX_I(10'h000), .OP_DONE_I(done_p),
        .OP_FAIL_I(fail), .WP_N_I(wp_n), .HOLD_RST_N_I(hold_n), .SCK_I(sck), .CS_N_I(cs_n), .SO_O(so),
        .BUSY_O(busy), .START_PROG_O(sp), .START_ERASE_O(se), .START_WRSR_O(sw), .SUSPEND_O(sus),
        .RESUME_O(res), .ENGINE_RESET_O(er), .PAUSE_O(pause), .DATA_LINES_O(dl), .PROT_LEVEL_O(lvl),
        .PROT_BOTTOM_O(pb), .PROT_INVERT_O(pi), .PROT_SCHEME_O(ps), .SECURE_LOCK_O(sl),
        .DRIVE_PCT_O(drv), .ADDR_4B_O(a4));
    flash_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .so_i(so));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(logic [7:0] o, logic [7:0] d = 8'h00, logic p = 1'b0);
        op = o;
        dat = d;
        prot = p;
        stb = 1'b1;
        @(negedge clk);
        stb = 1'b0;
        pulses = {sp, se, sw, sus, res};
        @(negedge clk);
    endtask
    task automatic rd(logic [7:0] o, logic [7:0] e, string n, logic [7:0] m = 8'hFF);
        u_host.frame(1'b1);
        repeat (3) @(negedge clk);
        cmd(o);
        u_host.xfer(got);
        u_host.frame(1'b0);
        chk(n, e, got & m);
        @(negedge clk);
    endtask
    task automatic done(logic f);
        fail = f;
        done_p = 1'b1;
        @(negedge clk);
        done_p = 1'b0;
        fail = 1'b0;
        @(negedge clk);
    endtask
    // A refused write leaves the latch set, so it is cleared here to keep later steps independent.
    task automatic wrsr(logic [7:0] o, logic [7:0] d, logic ok);
        cmd(`OP_WREN);
        cmd(o, d);
        chk("wrsr start", {5'h00, ok, 2'b00}, {3'b000, pulses});
        if (ok) begin
            done(1'b0);
        end else begin
            cmd(`OP_WRDI);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #3000000;
        failures++;
        give_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rst_n, stb, prot, done_p, fail, op, dat, area} = '0;
        {wp_n, hold_n} = 2'b11;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(`OP_RDSR1, 8'h00, "sr1");
        rd(`OP_RDSR2, 8'h00, "sr2");
        rd(`OP_RDSR3, 8'h00, "sr3");
        chk("drive", 8'h32, {1'b0, drv});
        cmd(`OP_WREN);
        rd(`OP_RDSR1, 8'h02, "sr1 latch");
        cmd(`OP_WRDI);
        rd(`OP_RDSR1, 8'h00, "sr1 latch");
        cmd(`OP_WRSR1, 8'hFC);
        chk("wrsr start", 8'h00, {3'b000, pulses});
        $display("latch test done");
        for (int k = 0; k < 2; k++) begin
            cmd(`OP_WREN);
            cmd(k ? `OP_SE : `OP_PP);
            chk("op start", k ? 8'h08 : 8'h10, {3'b000, pulses});
            cmd(`OP_SUSPEND);
            rd(`OP_RDSR2, k ? 8'h80 : 8'h04, "suspend");
            cmd(`OP_RESUME);
            rd(`OP_RDSR2, 8'h00, "resume");
            done(1'b1);
            rd(`OP_RDSR3, k ? 8'h10 : 8'h08, "fault", k ? 8'h10 : 8'h08);
            cmd(`OP_WREN);
            cmd(k ? `OP_SE : `OP_PP, 8'h00, 1'b1);
            chk("protected start", 8'h00, {3'b000, pulses});
            rd(`OP_RDSR1, 8'h00, "sr1 after fault");
        end
        $display("suspend and fault test done");
        cmd(`OP_WREN);
        cmd(`OP_WRSR1, 8'h58);
        rd(`OP_RDSR1, 8'h5B, "sr1 busy");
        done(1'b0);
        rd(`OP_RDSR1, 8'h58, "sr1");
        chk("level", 8'h06, {4'h0, lvl});
        chk("bottom", 8'h01, {7'h00, pb});
        for (int c = 0; c < 4; c++) begin
            wrsr(`OP_WRSR3, {1'b0, c[1:0], 5'h04}, 1'b1);
            chk("drive", drv_tab[c], {1'b0, drv});
        end
        chk("scheme", 8'h01, {7'h00, ps});
        cmd(`OP_WREN);
        cmd(`OP_PP);
        chk("locked start", 8'h00, {3'b000, pulses});
        cmd(`OP_BLK_UNLOCK);
        cmd(`OP_WREN);
        cmd(`OP_PP);
        chk("unlocked start", 8'h10, {3'b000, pulses});
        done(1'b0);
        cmd(`OP_EN4B);
        rd(`OP_RDSR3, 8'h01, "width", 8'h01);
        chk("width", 8'h01, {7'h00, a4});
        cmd(`OP_EX4B);
        chk("width", 8'h00, {7'h00, a4});
        wrsr(`OP_WRSR2, 8'h42, 1'b1);
        hold_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("quad invert", 8'h03, {6'h00, dl, pi});
        chk("pause", 8'h00, {7'h00, pause});
        wrsr(`OP_WRSR2, 8'h08, 1'b1);
        repeat (4) @(negedge clk);
        chk("pause", 8'h01, {7'h00, pause});
        hold_n = 1'b1;
        wrsr(`OP_WRSR3, 8'h80, 1'b1);
        hold_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset pin", 8'h02, {6'h00, er, pause});
        hold_n = 1'b1;
        repeat (4) @(negedge clk);
        wrsr(`OP_WRSR2, 8'h00, 1'b1);
        chk("secure lock", 8'h01, {5'h00, sl});
        area = 2'h1;
        cmd(`OP_WREN);
        cmd(`OP_PP);
        chk("secure start", 8'h00, {3'b000, pulses});
        area = 2'h0;
        $display("config test done");
        wrsr(`OP_WRSR1, 8'h80, 1'b1);
        wp_n = 1'b0;
        repeat (4) @(negedge clk);
        wrsr(`OP_WRSR1, 8'h84, 1'b0);
        chk("level", 8'h00, {4'h0, lvl});
        wp_n = 1'b1;
        repeat (4) @(negedge clk);
        wrsr(`OP_WRSR1, 8'h04, 1'b1);
        wrsr(`OP_WRSR2, 8'h09, 1'b1);
        wrsr(`OP_WRSR1, 8'h00, 1'b0);
        cmd(`OP_RSTEN);
        cmd(`OP_RST);
        rd(`OP_RDSR2, 8'h08, "sr2 lock mode");
        wrsr(`OP_WRSR1, 8'h80, 1'b1);
        wrsr(`OP_WRSR2, 8'h09, 1'b1);
        cmd(`OP_RSTEN);
        cmd(`OP_RST);
        wrsr(`OP_WRSR1, 8'h00, 1'b0);
        rd(`OP_RDSR1, 8'h80, "sr1 locked");
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(`OP_RDSR1, 8'h00, "sr1 power cycle");
        $display("lock mode test done");
        give_verdict();
    end
endmodule
